// ===== design/tmss_pkg.sv
// Constants for the touch matrix scan sequencer
// Assumes a 100 MHz sys_clk
package tmss_pkg;
	localparam int          CLK_MHZ        = 100;
	localparam int          NUM_DRIVE      = 8;
	localparam int          NUM_RECV       = 2;
	localparam int          NUM_KEYS       = 16;
	localparam int          KEY_W          = 4;
	localparam int          BL_W           = 8;
	localparam int          MEAS_W         = 12;
	localparam logic [11:0] MEAS_MAX       = 12'hfff;
	// Cycle period and dwell time in their own units
	localparam int          CYCLE_PERIOD_MS = 16;
	localparam int          DWELL_NS        = 250;
	localparam int          CYCLE_CLKS      = CYCLE_PERIOD_MS * 1000 * 1000 / 10;
	localparam int          DWELL_CLKS      = (DWELL_NS * CLK_MHZ + 999) / 1000;
	localparam int          CLAMP_CLKS      = 25;
	localparam int          CNT_W           = 21;
	localparam logic [KEY_W-1:0] FIRST_KEY  = 4'h0;
endpackage

// ===== design/tmss_timer.sv
// Down counter giving a one-cycle done pulse after a loaded delay
// Assumes the same sys_clk and srst as the sequencer
`timescale 1ns/1ps
module tmss_timer (
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	input  wire logic                      load,
	input  wire logic [tmss_pkg::CNT_W-1:0] count,
	output logic                           done
);
	logic [tmss_pkg::CNT_W-1:0] cnt_reg;
	logic                       run_reg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else if (load) begin
			cnt_reg <= count;
			run_reg <= 1'b1;
		end else if (run_reg) begin
			cnt_reg <= cnt_reg - 1'b1;
			if (cnt_reg <= 21'h000001)
				run_reg <= 1'b0;
		end
	end

	assign done = run_reg && (cnt_reg == 21'h000001);
endmodule

// ===== design/tmss_seq.sv
// Touch matrix scan sequencer: drive bursts, clamp, ramp timing
// Assumes comparator input from the analog front end, asynchronous
`timescale 1ns/1ps
// Overview of operation
// - Scan one key at a time, each cycle starting at key 0.
// - Order: drives 0..7 on receive 0, then drives 0..7 on receive 1.
// - Key index is eight times receive line plus drive line.
// - Each key bursts its own pulse count setting.
// - Finish a burst, then convert and report before next key.
// - Keys with zero pulse count are skipped, no idle slot.
// - Cycles start every 16 ms; sleep once all keys are done.
// - Clamp receive line to ground on each pulse falling edge.
// - After burst clamp receive line, time ramp to zero crossing.
// - Each pulse high dwell lasts at least 250 ns.
module tmss_seq (
	input  wire logic                                             sys_clk,
	input  wire logic                                             srst,
	input  wire logic [tmss_pkg::NUM_KEYS*tmss_pkg::BL_W-1:0]     pulse_count_setting,
	input  wire logic                                             zero_cross,
	output logic      [tmss_pkg::NUM_DRIVE-1:0]                   drive_out,
	output logic      [tmss_pkg::NUM_RECV-1:0]                    recv_clamp,
	output logic      [tmss_pkg::KEY_W-1:0]                       result_key,
	output logic      [tmss_pkg::MEAS_W-1:0]                      result_value,
	output logic                                                  result_valid,
	output logic                                                  sleeping
);
	typedef enum logic [2:0] {TMSS_SLEEP, TMSS_PICK, TMSS_HIGH, TMSS_LOW,
		TMSS_CLAMP, TMSS_RAMP} tmss_state_e;

	// ==========================================
	// Input synchroniser
	logic zc_meta_reg;
	logic zc_sync_reg;
	always_ff @(posedge sys_clk) begin
		zc_meta_reg <= zero_cross;
		zc_sync_reg <= zc_meta_reg;
	end

	// ==========================================
	// State
	tmss_state_e                   state_reg;
	tmss_state_e                   state_next;
	logic [tmss_pkg::KEY_W-1:0]    key_reg;
	logic [tmss_pkg::BL_W-1:0]     pulses_reg;
	logic [tmss_pkg::MEAS_W-1:0]   meas_reg;
	logic [tmss_pkg::CNT_W-1:0]    cycle_reg;
	logic                          last_key_reg;

	function automatic logic [tmss_pkg::BL_W-1:0] key_bl(input logic [3:0] k);
		key_bl = pulse_count_setting[k*tmss_pkg::BL_W +: tmss_pkg::BL_W];
	endfunction

	// Key = 8*receive + drive, so low bits drive, top bit receive
	wire [2:0] drive_idx = key_reg[2:0];
	wire       recv_idx  = key_reg[3];
	wire       key_en    = key_bl(key_reg) != 8'h00;
	wire       cycle_tick = cycle_reg == 21'h000000;
	wire       at_last    = key_reg == 4'hf;
	wire       meas_full  = meas_reg == tmss_pkg::MEAS_MAX;

	// Phase timer for dwell and clamp lengths
	logic                       tmr_load;
	logic [tmss_pkg::CNT_W-1:0] tmr_count;
	logic                       tmr_done;
	tmss_timer u_timer (
		.sys_clk (sys_clk),
		.srst    (srst),
		.load    (tmr_load),
		.count   (tmr_count),
		.done    (tmr_done)
	);

	always_comb begin
		state_next = state_reg;
		tmr_load   = 1'b0;
		tmr_count  = 21'(tmss_pkg::DWELL_CLKS);
		unique case (state_reg)
			TMSS_SLEEP: if (cycle_tick) state_next = TMSS_PICK;
			TMSS_PICK: begin
				if (key_en) begin
					state_next = TMSS_HIGH;
					tmr_load   = 1'b1;
				end else if (at_last) begin
					state_next = TMSS_SLEEP;
				end
			end
			TMSS_HIGH: if (tmr_done) begin
				state_next = TMSS_LOW;
				tmr_load   = 1'b1;
				tmr_count  = 21'(tmss_pkg::CLAMP_CLKS);
			end
			TMSS_LOW: if (tmr_done) begin
				tmr_load = 1'b1;
				if (pulses_reg == 8'h01) begin
					state_next = TMSS_CLAMP;
					tmr_count  = 21'(tmss_pkg::CLAMP_CLKS);
				end else begin
					state_next = TMSS_HIGH;
				end
			end
			TMSS_CLAMP: if (tmr_done) state_next = TMSS_RAMP;
			TMSS_RAMP: if (zc_sync_reg || meas_full)
				state_next = last_key_reg ? TMSS_SLEEP : TMSS_PICK;
			default: state_next = TMSS_SLEEP;
		endcase
	end

	// ==========================================
	// Sequencing registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg    <= TMSS_SLEEP;
			key_reg      <= tmss_pkg::FIRST_KEY;
			pulses_reg   <= 8'h00;
			meas_reg     <= 12'h000;
			last_key_reg <= 1'b0;
			cycle_reg    <= 21'h000000;
		end else begin
			state_reg <= state_next;
			cycle_reg <= cycle_tick ? 21'(tmss_pkg::CYCLE_CLKS - 1)
				: cycle_reg - 21'h000001;
			if (state_reg == TMSS_SLEEP)
				key_reg <= tmss_pkg::FIRST_KEY;
			else if (state_reg == TMSS_PICK && !key_en && !at_last)
				key_reg <= key_reg + 4'h1;
			else if (state_reg == TMSS_RAMP && state_next == TMSS_PICK)
				key_reg <= key_reg + 4'h1;
			if (state_reg == TMSS_PICK) begin
				pulses_reg   <= key_bl(key_reg);
				last_key_reg <= at_last;
			end else if (state_reg == TMSS_LOW && tmr_done)
				pulses_reg <= pulses_reg - 8'h01;
			if (state_reg == TMSS_CLAMP)
				meas_reg <= 12'h000;
			else if (state_reg == TMSS_RAMP && !meas_full)
				meas_reg <= meas_reg + 12'h001;
		end
	end

	// ==========================================
	// Outputs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			drive_out    <= 8'h00;
			recv_clamp   <= 2'h0;
			result_key   <= 4'h0;
			result_value <= 12'h000;
			result_valid <= 1'b0;
			sleeping     <= 1'b1;
		end else begin
			drive_out  <= (state_next == TMSS_HIGH) ? (8'h01 << drive_idx) : 8'h00;
			recv_clamp <= (state_next == TMSS_LOW || state_next == TMSS_CLAMP)
				? (recv_idx ? 2'h2 : 2'h1) : 2'h0;
			sleeping     <= state_next == TMSS_SLEEP;
			result_valid <= state_reg == TMSS_RAMP && state_next != TMSS_RAMP;
			if (state_reg == TMSS_RAMP && state_next != TMSS_RAMP) begin
				result_key   <= key_reg;
				result_value <= meas_reg;
			end
		end
	end
endmodule

// ===== dv/tmss_matrix_model.sv
// Electrode matrix stand-in: ramp crosses zero ramp_len clocks after clamp release
// Assumes ramp_len of zero never crosses
`timescale 1ns/1ps
module tmss_matrix_model (
	input  wire logic        sys_clk,
	input  wire logic [7:0]  drive_out,
	input  wire logic [1:0]  recv_clamp,
	input  wire logic [11:0] ramp_len,
	output logic             zero_cross
);
	logic [12:0] ramp_reg;
	always_ff @(posedge sys_clk) begin
		if (|recv_clamp || |drive_out)
			ramp_reg <= 13'h0000;
		else
			ramp_reg <= ramp_reg + 13'h0001;
	end
	// Touch threshold is the host's business, not modelled here
	// Goes high while idle too, dropping for ramp_len clocks each time the 13-bit ramp_reg wraps; design must ignore it
	assign zero_cross = (ramp_len != 12'h000) && (ramp_reg >= {1'b0, ramp_len});
endmodule

// ===== dv/tmss_seq_sva.sv
// Port timing checker for tmss_seq
// Assumes binding to tmss_seq
`timescale 1ns/1ps
module tmss_seq_sva (
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic [7:0]  drive_out,
	input wire logic [1:0]  recv_clamp,
	input wire logic [3:0]  result_key,
	input wire logic [11:0] result_value,
	input wire logic        result_valid,
	input wire logic        sleeping
);
	logic [7:0] hi_cnt;
	always_ff @(posedge sys_clk) hi_cnt <= (|drive_out) ? hi_cnt + 8'h01 : 8'h00;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence pulse_end;
		$fell(|drive_out);
	endsequence
	a_one_drive: assert property ($onehot0(drive_out)) else $error("drive not one-hot");
	a_one_clamp: assert property ($onehot0(recv_clamp)) else $error("two clamps");
	a_dwell_min: assert property (pulse_end |-> hi_cnt >= 8'h19) else $error("short dwell");
	a_clamp_on_fall: assert property (pulse_end |-> |recv_clamp) else $error("no clamp");
	a_clamp_apart: assert property (|drive_out |-> !(|recv_clamp)) else $error("clamp in dwell");
	a_clamp_hold: assert property ($rose(|recv_clamp) |-> (|recv_clamp)[*8])
		else $error("clamp too short");
	a_valid_single: assert property (result_valid |=> !result_valid) else $error("long valid");
	a_result_hold: assert property (!result_valid |-> $stable(result_key) && $stable(result_value))
		else $error("result moved");
	a_sleep_quiet: assert property (sleeping |-> drive_out == 8'h00 && recv_clamp == 2'h0)
		else $error("active in sleep");
endmodule
bind tmss_seq tmss_seq_sva tmss_seq_sva_inst (.sys_clk(sys_clk), .srst(srst),
	.drive_out(drive_out), .recv_clamp(recv_clamp), .result_key(result_key),
	.result_value(result_value), .result_valid(result_valid), .sleeping(sleeping));

// ===== dv/touch_matrix_scan_sequencer_bench.sv
// Self-checking bench for tmss_seq: one scan after reset
// Assumes the matrix model answers each ramp except key 15's, whose zero ramp_len never crosses
`timescale 1ns/1ps
module touch_matrix_scan_sequencer_bench;
	logic         sys_clk;
	logic         srst;
	logic [127:0] pulse_count_setting;
	logic [11:0]  ramp_len;
	logic         zero_cross;
	logic [7:0]   drive_out;
	logic [1:0]   recv_clamp;
	logic [3:0]   result_key;
	logic [11:0]  result_value;
	logic         result_valid;
	logic         sleeping;
	int           fail_count;
	int           n_checks;
	tmss_seq tmss_seq_inst (.sys_clk(sys_clk), .srst(srst), .zero_cross(zero_cross),
		.pulse_count_setting(pulse_count_setting), .drive_out(drive_out),
		.recv_clamp(recv_clamp), .result_key(result_key), .result_value(result_value),
		.result_valid(result_valid), .sleeping(sleeping));
	tmss_matrix_model tmss_matrix_model_inst (.sys_clk(sys_clk), .drive_out(drive_out),
		.recv_clamp(recv_clamp), .ramp_len(ramp_len), .zero_cross(zero_cross));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// Wait one result, counting pulses and checking lines used
	task automatic expect_key(input logic [3:0] k, input int n, input logic [11:0] d);
		int cnt;
		int i;
		logic [7:0] pd;
		cnt = 0;
		pd = 8'h00;
		ramp_len = d;
		for (i = 0; i < 9000; i++) begin
			@(posedge sys_clk);
			#1;
			if (|drive_out && pd == 8'h00) begin
				cnt++;
				chk(drive_out === 8'h01 << k[2:0], "drive line");
			end
			if (|recv_clamp)
				chk(recv_clamp === 2'h1 << k[3], "clamp line");
			pd = drive_out;
			if (result_valid === 1'b1)
				break;
		end
		chk(result_valid === 1'b1, "no result");
		if (result_valid !== 1'b1)
			results();
		chk(result_key === k, "key order");
		chk(cnt == n, "pulse count");
		chk(sleeping === (k == 4'hf), "sleep state");
		if (d == 12'h000)
			chk(result_value === tmss_pkg::MEAS_MAX, "saturation");
		else
			chk(result_value >= d && result_value <= d + 12'h004, "ramp time");
	endtask
	task automatic scan_order();
		expect_key(4'h0, 1, 12'h005);
		expect_key(4'h2, 2, 12'h009);
		expect_key(4'h7, 1, 12'h003);
		expect_key(4'h8, 1, 12'h007);
	endtask
	task automatic no_crossing();
		expect_key(4'hf, 3, 12'h000);
	endtask
	task automatic sleep_after();
		int i;
		for (i = 0; i < 2000; i++) begin
			@(posedge sys_clk);
			#1;
			if (i > 20)
				chk(sleeping === 1'b1 && result_valid === 1'b0, "not asleep");
		end
	endtask
	initial begin
		fail_count = 0;
		n_checks = 0;
		srst = 1'b1;
		ramp_len = 12'h005;
		pulse_count_setting = {8'h03, 48'h0, 8'h01, 8'h01, 32'h0, 8'h02, 8'h00, 8'h01};
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		scan_order();
		no_crossing();
		sleep_after();
		results();
	end
endmodule
